/* File: dpsem_cycle.sv */
// Single semaphore bus cycle sequencer for one port
`timescale 1ns/10ps
`default_nettype none
`include "dpsem_params.svh"

module dpsem_cycle (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Cycle request
    input wire logic i_start,
    input wire logic i_is_write,
    // Cycle phase outputs
    output logic o_active,
    output logic o_sample,
    output logic o_done
);
    localparam logic [3:0] ACC_CYC = 4'(`DPSEM_ACCESS_CYC);

    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic wr_r;
    logic wr_nxt;

    // ==========================================
    // Cycle counter
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        wr_nxt = wr_r;
        if (!busy_r && i_start) begin
            busy_nxt = 1'b1;
            wr_nxt = i_is_write;
            cnt_nxt = ACC_CYC;
        end else if (busy_r) begin
            if (cnt_r == 4'h1) begin
                busy_nxt = 1'b0;
            end
            cnt_nxt = cnt_r - 4'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
            wr_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            wr_r <= wr_nxt;
        end
    end

    // Phase decode
    assign o_active = busy_r;
    assign o_sample = busy_r && !wr_r && (cnt_r == 4'h1);
    assign o_done = busy_r && (cnt_r == 4'h1);

    // ==========================================
    // Checks
    chk_cycle_length: assert property (@(posedge i_clk) disable iff (i_rst)
        (!busy_r && i_start) |=> o_active [*3] ##1 !o_active)
        else $error("cycle length wrong");
endmodule : dpsem_cycle
`default_nettype wire

/* File: dpsem_dev_model.sv */
// Behavioural two-port semaphore device with eight flags
`timescale 1ns/10ps
`default_nettype none

module dpsem_dev_model (
    // Sampling clock
    input wire logic i_clk,
    // Controller port pins
    input wire logic i_a_ce_n,
    input wire logic i_a_sel_n,
    input wire logic i_a_ben_n,
    input wire logic i_a_oe_n,
    input wire logic i_a_rw_n,
    input wire logic [15:0] i_a_addr,
    input wire logic [35:0] i_a_d,
    output logic [35:0] o_a_q,
    // Second processor pins
    input wire logic i_b_sel_n,
    input wire logic i_b_oe_n,
    input wire logic i_b_rw_n,
    input wire logic [15:0] i_b_addr,
    input wire logic [35:0] i_b_d,
    output logic [35:0] o_b_q
);
    // ==========================================
    // Flag state, power-up contents arbitrary
    logic [7:0] req [2] = '{8'h5a, 8'h3c};
    logic [1:0] own [8];
    logic [1:0] lat = 2'h3;
    logic [1:0] act_r = 2'h0;
    logic [1:0] act;
    logic [1:0] wr;
    initial for (int k = 0; k < 8; k++) own[k] = !req[0][k] ? 2'h1 : (!req[1][k] ? 2'h2 : 2'h0);

    // Decode of writes and reads; chip enable must be high
    assign wr[0] = i_a_ce_n && !i_a_sel_n && !i_a_rw_n;
    assign wr[1] = !i_b_sel_n && !i_b_rw_n;
    assign act[0] = i_a_ce_n && !i_a_sel_n && !i_a_ben_n && !i_a_oe_n && i_a_rw_n;
    assign act[1] = !i_b_sel_n && !i_b_oe_n && i_b_rw_n;

    // Request latch update for one side
    task automatic put(input int s, input logic [2:0] k, input logic v);
        req[s][k] = v;
        if (own[k] == 2'(s + 1) && v) own[k] = req[1 - s][k] ? 2'h0 : 2'(2 - s);
        else if (own[k] == 2'h0 && !v) own[k] = 2'(s + 1);
    endtask : put

    // Side A served first, so a true tie goes to A
    always @(posedge i_clk) begin
        if (wr[0]) put(0, i_a_addr[2:0], i_a_d[0]);
        if (wr[1]) put(1, i_b_addr[2:0], i_b_d[0]);
        if (act[0] && !act_r[0]) lat[0] <= own[i_a_addr[2:0]] != 2'h1;
        if (act[1] && !act_r[1]) lat[1] <= own[i_b_addr[2:0]] != 2'h2;
        act_r <= act;
    end

    // Latched flag on every bit, inverse when not reading
    assign o_a_q = (act[0] && act_r[0]) ? {36{lat[0]}} : ~{36{lat[0]}};
    assign o_b_q = (act[1] && act_r[1]) ? {36{lat[1]}} : ~{36{lat[1]}};
endmodule : dpsem_dev_model
`default_nettype wire

/* File: dpsem_host.sv */
// Host side controller driving one port of the semaphore space
// Operation
// (RQ1) Eight independent flags, one token each
// (RQ2) Write zero requests, write one releases
// (RQ3) Flag chosen by three low address bits
// (RQ4) Only data bit zero carries written value
// (RQ5) Zero on free flag gives ownership here
// (RQ6) Owner writing one frees the flag
// (RQ7) Losing zero waits in request latch
// (RQ8) Pending request takes ownership on release
// (RQ9) First request latch owns until written one
// (RQ10) Simultaneous requests yield exactly one winner
// (RQ11) Read value spread over every data bit
// (RQ12) Read latched while select and enable active
// (RQ13) Drop select or enable between polls
// (RQ14) Byte enable only gates read output
// (RQ15) Acquire by write then read back
// (RQ16) Failed request: keep polling or withdraw
// (RQ17) Write one everywhere at power-up
// (RQ18) No wait states, no hardware gating
// (RQ19) Chip enable high while select low
`timescale 1ns/10ps
`default_nettype none
`include "dpsem_params.svh"

module dpsem_host (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // User command port
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd,
    input wire logic [`DPSEM_INDEX_W-1:0] i_cmd_index,
    output logic o_cmd_ready,
    // User result
    output logic o_res_valid,
    output logic o_res_owned,
    output logic o_init_done,
    // Device port pins
    output logic o_chip_enable_n,
    output logic o_semaphore_select_n,
    output logic o_byte_lane_enable_n,
    output logic o_output_enable_n,
    output logic o_read_write_n,
    output logic [`DPSEM_ADDR_W-1:0] o_addr,
    // Data pins, three signals each
    input wire logic [`DPSEM_DATA_W-1:0] i_data,
    output logic [`DPSEM_DATA_W-1:0] o_data,
    output logic o_data_oe_n
);
    localparam logic [3:0] GAP_CYC = 4'(`DPSEM_GAP_CYC);
    localparam logic [3:0] LAST_FLAG = 4'(`DPSEM_FLAG_COUNT - 1);

    dpsem_pkg::dpsem_state_e st_r;
    dpsem_pkg::dpsem_state_e st_nxt;
    dpsem_pkg::dpsem_cmd_t cmd_r;
    dpsem_pkg::dpsem_cmd_t cmd_nxt;
    logic [`DPSEM_INDEX_W-1:0] idx_r;
    logic [`DPSEM_INDEX_W-1:0] idx_nxt;
    logic [3:0] gap_r;
    logic [3:0] gap_nxt;
    logic wbit_r;
    logic wbit_nxt;
    logic owned_r;
    logic owned_nxt;
    logic res_valid_r;
    logic res_valid_nxt;
    logic init_done_r;
    logic init_done_nxt;
    logic [3:0] init_cnt_r;
    logic [3:0] init_cnt_nxt;
    logic cyc_start;
    logic cyc_write;
    logic cyc_active;
    logic cyc_sample;
    logic cyc_done;

    // Flag value read back: majority not needed, all bits equal
    function automatic logic flag_of(input logic [`DPSEM_DATA_W-1:0] d);
        flag_of = d[0]; // RQ11
    endfunction : flag_of

    // ==========================================
    // Bus cycle sequencer
    dpsem_cycle u_cycle (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(cyc_start),
        .i_is_write(cyc_write),
        .o_active(cyc_active),
        .o_sample(cyc_sample),
        .o_done(cyc_done)
    );

    // ==========================================
    // Command sequencing next state
    always_comb begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        idx_nxt = idx_r;
        gap_nxt = gap_r;
        wbit_nxt = wbit_r;
        owned_nxt = owned_r;
        res_valid_nxt = 1'b0;
        init_done_nxt = init_done_r;
        init_cnt_nxt = init_cnt_r;
        cyc_start = 1'b0;
        cyc_write = 1'b0;
        case (st_r)
            dpsem_pkg::DPSEM_IDLE: begin
                if (!init_done_r) begin
                    // Free every flag from this side after reset
                    cmd_nxt = `DPSEM_CMD_INIT; // RQ17
                    idx_nxt = init_cnt_r[`DPSEM_INDEX_W-1:0];
                    wbit_nxt = 1'b1;
                    st_nxt = dpsem_pkg::DPSEM_WRITE;
                end else if (i_cmd_valid) begin
                    cmd_nxt = i_cmd;
                    idx_nxt = i_cmd_index;
                    // Acquire writes zero, release and withdraw write one
                    wbit_nxt = (i_cmd != `DPSEM_CMD_ACQUIRE); // RQ2 RQ16
                    st_nxt = (i_cmd == `DPSEM_CMD_POLL) ? dpsem_pkg::DPSEM_GAP : dpsem_pkg::DPSEM_WRITE;
                    gap_nxt = GAP_CYC;
                end
            end
            dpsem_pkg::DPSEM_WRITE: begin
                cyc_start = !cyc_active;
                cyc_write = 1'b1;
                if (cyc_done) begin
                    gap_nxt = GAP_CYC;
                    // Acquire always reads back after its write
                    st_nxt = (cmd_r == `DPSEM_CMD_ACQUIRE) ? dpsem_pkg::DPSEM_GAP
                                                           : dpsem_pkg::DPSEM_DONE; // RQ15
                end
            end
            dpsem_pkg::DPSEM_GAP: begin
                // Select released between cycles so read latch refreshes
                gap_nxt = gap_r - 4'h1; // RQ13
                if (gap_r <= 4'h1) begin
                    st_nxt = dpsem_pkg::DPSEM_READ;
                end
            end
            dpsem_pkg::DPSEM_READ: begin
                cyc_start = !cyc_active;
                if (cyc_sample) begin
                    owned_nxt = !flag_of(i_data); // RQ5 RQ7
                end
                if (cyc_done) begin
                    st_nxt = dpsem_pkg::DPSEM_DONE;
                end
            end
            dpsem_pkg::DPSEM_DONE: begin
                // Reserved code after start-up is a plain write of one
                if (cmd_r == `DPSEM_CMD_INIT && !init_done_r) begin
                    if (init_cnt_r == LAST_FLAG) begin
                        init_done_nxt = 1'b1;
                    end
                    init_cnt_nxt = init_cnt_r + 4'h1;
                end else begin
                    res_valid_nxt = 1'b1;
                    if (cmd_r == `DPSEM_CMD_RELEASE || cmd_r == `DPSEM_CMD_INIT) begin
                        owned_nxt = 1'b0; // RQ6 RQ8
                    end
                end
                st_nxt = dpsem_pkg::DPSEM_IDLE;
            end
            default: begin
                st_nxt = dpsem_pkg::DPSEM_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= dpsem_pkg::DPSEM_IDLE;
            cmd_r <= 2'h0;
            idx_r <= 3'h0;
            gap_r <= 4'h0;
            wbit_r <= 1'b1;
            owned_r <= 1'b0;
            res_valid_r <= 1'b0;
            init_done_r <= 1'b0;
            init_cnt_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            idx_r <= idx_nxt;
            gap_r <= gap_nxt;
            wbit_r <= wbit_nxt;
            owned_r <= owned_nxt;
            res_valid_r <= res_valid_nxt;
            init_done_r <= init_done_nxt;
            init_cnt_r <= init_cnt_nxt;
        end
    end

    // ==========================================
    // Pin drive
    assign o_cmd_ready = init_done_r && (st_r == dpsem_pkg::DPSEM_IDLE);
    assign o_res_valid = res_valid_r;
    assign o_res_owned = owned_r;
    assign o_init_done = init_done_r;
    assign o_chip_enable_n = 1'b1; // RQ19
    assign o_semaphore_select_n = !cyc_active;
    assign o_output_enable_n = !(cyc_active && st_r == dpsem_pkg::DPSEM_READ); // RQ12
    assign o_byte_lane_enable_n = !cyc_active; // RQ14
    assign o_read_write_n = !(cyc_active && st_r == dpsem_pkg::DPSEM_WRITE);
    // Only low address bits select a flag
    assign o_addr = {{(`DPSEM_ADDR_W-`DPSEM_INDEX_W){1'b0}}, idx_r}; // RQ3 RQ1
    // Written value on data bit zero, upper bits copy it
    assign o_data = {`DPSEM_DATA_W{wbit_r}}; // RQ4
    assign o_data_oe_n = !(cyc_active && st_r == dpsem_pkg::DPSEM_WRITE);

    // ==========================================
    // Checks
    chk_ce_held_high: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_semaphore_select_n |-> o_chip_enable_n) // RQ19
        else $error("chip enable low in semaphore cycle");
    chk_acquire_reads_back: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_r == dpsem_pkg::DPSEM_WRITE && cyc_done && cmd_r == `DPSEM_CMD_ACQUIRE)
        |=> st_r == dpsem_pkg::DPSEM_GAP) // RQ15
        else $error("acquire without read back");
    chk_poll_gap: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_r == dpsem_pkg::DPSEM_GAP) |-> o_semaphore_select_n && o_output_enable_n) // RQ13
        else $error("select held across polls");
    chk_write_bit: assert property (@(posedge i_clk) disable iff (i_rst)
        (!o_read_write_n && cmd_r == `DPSEM_CMD_ACQUIRE) |-> !o_data[0]) // RQ2
        else $error("acquire not writing zero");
    chk_init_ones: assert property (@(posedge i_clk) disable iff (i_rst)
        (!o_read_write_n && !init_done_r) |-> o_data[0]) // RQ17
        else $error("init not writing one");
    chk_addr_high: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_semaphore_select_n |-> o_addr[`DPSEM_ADDR_W-1:`DPSEM_INDEX_W] == '0) // RQ3
        else $error("high address bits set");
    chk_owned_sample: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_r == dpsem_pkg::DPSEM_READ && cyc_sample) |=> owned_r == !$past(i_data[0])) // RQ11
        else $error("owned not from read flag");
    chk_release_clears: assert property (@(posedge i_clk) disable iff (i_rst)
        (res_valid_r && cmd_r == `DPSEM_CMD_RELEASE) |-> !owned_r) // RQ6
        else $error("owned after release");
endmodule : dpsem_host
`default_nettype wire

/* File: dpsem_params.svh */
// Constants for the semaphore port controller
`ifndef DPSEM_PARAMS_SVH
`define DPSEM_PARAMS_SVH

// Semaphore space geometry
`define DPSEM_FLAG_COUNT 8
`define DPSEM_INDEX_W 3
`define DPSEM_ADDR_W 16
`define DPSEM_DATA_W 36
// Bus cycle timing, nanoseconds and cycles at 5 ns
`define DPSEM_CLK_NS 5
`define DPSEM_ACCESS_NS 15
`define DPSEM_ACCESS_CYC ((`DPSEM_ACCESS_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`define DPSEM_GAP_NS 10
`define DPSEM_GAP_CYC ((`DPSEM_GAP_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
// Command encodings
`define DPSEM_CMD_ACQUIRE 2'h0
`define DPSEM_CMD_RELEASE 2'h1
`define DPSEM_CMD_POLL 2'h2
`define DPSEM_CMD_INIT 2'h3

`endif

/* File: dpsem_pkg.sv */
// Types for the semaphore port controller
`default_nettype none

package dpsem_pkg;
    typedef enum logic [2:0] {
        DPSEM_IDLE = 3'b000,
        DPSEM_WRITE = 3'b001,
        DPSEM_GAP = 3'b010,
        DPSEM_READ = 3'b011,
        DPSEM_DONE = 3'b100
    } dpsem_state_e;
    typedef logic [1:0] dpsem_cmd_t;
endpackage : dpsem_pkg
`default_nettype wire

/* File: dual_port_semaphore_flags_tb_top.sv */
// Testbench for the semaphore port controller
`timescale 1ns/10ps
`default_nettype none
`include "dpsem_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module dual_port_semaphore_flags_tb_top;
    // ==========================================
    // Stimulus and wiring
    logic i_clk = 0, i_rst = 1, cmd_valid = 0, got, ready, res_v, res_o, init_done;
    logic [1:0] cmd = 0;
    logic [1:0] c;
    logic [2:0] cmd_index = 0;
    logic [2:0] k;
    logic b_sel_n = 1, b_rw_n = 1, b_oe_n = 1, ce_n, sel_n, ben_n, oe_n, rw_n, doe_n;
    logic [15:0] b_addr = 0, addr;
    logic [35:0] b_d = 0, rd, a_q, b_q, a_d;
    logic [7:0] own_exp = 0;
    int bad_count = 0, check_count = 0, seed = 32'h7492bb08, n;

    always #2.5 i_clk = ~i_clk;

    dpsem_host dut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .i_cmd_index(cmd_index), .o_cmd_ready(ready), .o_res_valid(res_v), .o_res_owned(res_o),
        .o_init_done(init_done), .o_chip_enable_n(ce_n), .o_semaphore_select_n(sel_n),
        .o_byte_lane_enable_n(ben_n), .o_output_enable_n(oe_n), .o_read_write_n(rw_n),
        .o_addr(addr), .i_data(a_q), .o_data(a_d), .o_data_oe_n(doe_n));

    dpsem_dev_model dev (.i_clk(i_clk), .i_a_ce_n(ce_n), .i_a_sel_n(sel_n), .i_a_ben_n(ben_n),
        .i_a_oe_n(oe_n), .i_a_rw_n(rw_n), .i_a_addr(addr), .i_a_d(doe_n ? ~a_d : a_d), .o_a_q(a_q),
        .i_b_sel_n(b_sel_n), .i_b_oe_n(b_oe_n), .i_b_rw_n(b_rw_n), .i_b_addr(b_addr),
        .i_b_d(b_d), .o_b_q(b_q));

    // Verdict and end of run
    task automatic conclude();
        if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    task automatic tick(input int m);
        repeat (m) @(negedge i_clk);
    endtask : tick

    function automatic logic [35:0] word(input logic v);
        return {36{v}};
    endfunction : word

    // One command through the controller, bounded waits
    task automatic run(input logic [1:0] cc, input logic [2:0] kk, output logic ow);
        int m;
        ow = 1'bx;
        for (m = 0; m < 200 && ready !== 1'b1; m++) tick(1);
        if (m == 200) begin `CHK(1'b0, 1'b1) conclude(); end
        cmd_valid = 1;
        cmd = cc;
        cmd_index = kk;
        tick(1);
        cmd_valid = 0;
        for (m = 0; m < 60; m++) begin
            if (res_v === 1'b1) ow = res_o;
            if (ready === 1'b1) break;
            tick(1);
        end
        if (m == 60) begin `CHK(1'b0, 1'b1) conclude(); end
        if (res_v === 1'b1) ow = res_o;
    endtask : run

    // One access by the second processor, high address bits random
    task automatic b_acc(input logic w, input logic [2:0] kk, input logic v, output logic [35:0] q);
        b_addr = 16'($random(seed));
        b_addr[2:0] = kk;
        b_d = {$random(seed), 4'h0};
        b_d[0] = v;
        b_sel_n = 0;
        b_rw_n = !w;
        b_oe_n = w;
        tick(3);
        q = b_q;
        b_sel_n = 1;
        b_rw_n = 1;
        b_oe_n = 1;
        tick(1);
    endtask : b_acc

    // ==========================================
    // Main sequence
    initial begin
        tick(4);
        i_rst = 0;
        for (n = 0; n < 400 && init_done !== 1'b1; n++) tick(1);
        `CHK(init_done, 1'b1)
        if (init_done !== 1'b1) conclude();
        for (int j = 0; j < 8; j++) b_acc(1, 3'(j), 1, rd);
        for (int j = 0; j < 8; j++) begin
            b_acc(0, 3'(j), 0, rd);
            `CHK(rd, word(1))
        end
        // Token passing on one flag
        run(`DPSEM_CMD_ACQUIRE, 3'h5, got); `CHK(got, 1'b1)
        b_acc(1, 3'h5, 0, rd);
        b_acc(0, 3'h5, 0, rd); `CHK(rd, word(1))
        run(`DPSEM_CMD_RELEASE, 3'h5, got);
        b_acc(0, 3'h5, 0, rd); `CHK(rd, word(0))
        run(`DPSEM_CMD_ACQUIRE, 3'h5, got); `CHK(got, 1'b0)
        run(`DPSEM_CMD_POLL, 3'h5, got); `CHK(got, 1'b0)
        b_acc(1, 3'h5, 1, rd);
        run(`DPSEM_CMD_POLL, 3'h5, got); `CHK(got, 1'b1)
        run(`DPSEM_CMD_RELEASE, 3'h5, got);
        b_acc(0, 3'h5, 0, rd); `CHK(rd, word(1))
        // Near-simultaneous requests, the earlier one wins
        fork
            run(`DPSEM_CMD_ACQUIRE, 3'h2, got);
            b_acc(1, 3'h2, 0, rd);
        join
        b_acc(0, 3'h2, 0, rd); `CHK(rd, word(got))
        `CHK(got, 1'b0)
        run(`DPSEM_CMD_RELEASE, 3'h2, got);
        b_acc(1, 3'h2, 1, rd);
        // Random commands of every code
        repeat (60) begin
            k = 3'($random(seed));
            c = 2'($random(seed));
            run(c, k, got);
            if (c == `DPSEM_CMD_ACQUIRE) own_exp[k] = 1'b1;
            if (c == `DPSEM_CMD_RELEASE || c == `DPSEM_CMD_INIT) own_exp[k] = 1'b0;
            if (c == `DPSEM_CMD_ACQUIRE || c == `DPSEM_CMD_POLL) `CHK(got, own_exp[k])
            if (c == `DPSEM_CMD_RELEASE || c == `DPSEM_CMD_INIT) `CHK(got, 1'b0)
        end
        // Our side sees its own tokens, the other side always reads one
        for (int j = 0; j < 8; j++) begin
            run(`DPSEM_CMD_POLL, 3'(j), got);
            `CHK(got, own_exp[j])
            b_acc(0, 3'(j), 0, rd);
            `CHK(rd, word(1'b1))
        end
        conclude();
    end
endmodule : dual_port_semaphore_flags_tb_top
`default_nettype wire
